// *** bioc_bus_controller.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "bioc_defines.svh"

module bioc_bus_controller #(
  parameter int WAIT_W = `BIOC_WAIT_W,
  parameter logic [3:0] IO_SLOW_MASK = `BIOC_IO_SLOW_MASK,
  parameter logic [WAIT_W-1:0] WS_ROM = `BIOC_WS_ROM,
  parameter logic [WAIT_W-1:0] WS_RAM = `BIOC_WS_RAM,
  parameter logic [WAIT_W-1:0] WS_IO_FAST = `BIOC_WS_IO_FAST,
  parameter logic [WAIT_W-1:0] WS_IO_SLOW = `BIOC_WS_IO_SLOW,
  parameter logic [WAIT_W-1:0] WS_INT_ACK_CMD_N = `BIOC_WS_INT_ACK_CMD_N,
  parameter logic [WAIT_W-1:0] WS_OTHER = `BIOC_WS_OTHER
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [31:2] cpu_addr,
  input wire logic cpu_ads_n,
  input wire logic cpu_w_r,
  input wire logic cpu_m_io,
  input wire logic cpu_d_c,
  output logic [31:2] held_addr,
  output logic held_addr_oe_n,
  output logic latch_gate,
  output logic [3:0] mem_cs,
  output logic [3:0] io_cs,
  output logic xcvr_direction,
  output logic xcvr_enable_n,
  output logic rom_rd_cmd_n,
  output logic io_rd_cmd_n,
  output logic io_wr_cmd_n,
  output logic int_ack_cmd_n,
  output logic cpu_ready_n,
  output logic wait_done_n
);

  localparam logic [WAIT_W-1:0] IO_RECOVERY =
    WAIT_W'(`BIOC_IO_RECOVERY_CYC);

  bioc_pkg::bioc_state_t state;
  bioc_pkg::bioc_state_t next_state;
  bioc_pkg::bioc_cmd_t cmd;
  bioc_pkg::bioc_cmd_t next_cmd;
  logic cycle_start;
  logic cycle_end;
  logic wait_start;
  logic companion_read;
  logic mem_write;
  logic next_mem_write;
  logic io_slow;
  logic [WAIT_W-1:0] next_wait_count;

  // ----------------------------------------------------------------
  // sub-blocks
  // ----------------------------------------------------------------
  bioc_link_if #(.WAIT_W(WAIT_W)) link ();

  bioc_decoder u_decoder (
    .link(link.dec)
  );

  bioc_wait_counter #(.WAIT_W(WAIT_W)) u_wait_counter (
    .core_clk(core_clk),
    .reset(reset),
    .link(link.wct)
  );

  // decoder sees the raw processor address so selects are early
  assign link.mem_sel = cpu_addr[`BIOC_MEM_SEL_BIT];
  assign link.io_sel = cpu_addr[`BIOC_IO_SEL_HI:`BIOC_IO_SEL_LO];
  assign link.m_io = cpu_m_io;
  assign link.d_c = cpu_d_c;
  assign link.wait_start = wait_start;
  assign link.wait_count = next_wait_count;
  assign wait_done_n = link.wait_done_n;

  // ----------------------------------------------------------------
  // cycle sequencing
  // ----------------------------------------------------------------
  assign cycle_start = (state == bioc_pkg::ST_IDLE) && !cpu_ads_n;
  assign cycle_end = (state == bioc_pkg::ST_ACTIVE) && !link.wait_done_n;

  // a strobe while busy or in the ready cycle is ignored: no pipelining
  // the done state spends the ready cycle so no start can overlap it
  always_comb
  begin
    next_state = state;
    case (state)
      bioc_pkg::ST_IDLE:
      begin
        if (!cpu_ads_n)
        begin
          next_state = bioc_pkg::ST_ACTIVE;
        end
      end
      bioc_pkg::ST_ACTIVE:
      begin
        if (!link.wait_done_n)
        begin
          next_state = bioc_pkg::ST_DONE;
        end
      end
      bioc_pkg::ST_DONE:
      begin
        next_state = bioc_pkg::ST_IDLE;
      end
      default:
      begin
        next_state = bioc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state <= bioc_pkg::ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // status decode: {m_io, d_c, w_r}
  // ----------------------------------------------------------------
  always_comb
  begin
    next_cmd = bioc_pkg::CMD_NONE;
    // codes 001, 101 and 111 carry no command strobe
    case ({cpu_m_io, cpu_d_c, cpu_w_r})
      3'h0: next_cmd = bioc_pkg::CMD_INT_ACK;
      3'h2: next_cmd = bioc_pkg::CMD_IO_RD;
      3'h3: next_cmd = bioc_pkg::CMD_IO_WR;
      3'h4: next_cmd = bioc_pkg::CMD_ROM_RD;
      3'h6: next_cmd = bioc_pkg::CMD_ROM_RD;
      default: next_cmd = bioc_pkg::CMD_NONE;
    endcase
  end

  // memory writes carry no strobe but still move data
  assign next_mem_write = cpu_m_io && cpu_d_c && cpu_w_r;

  // ----------------------------------------------------------------
  // address and chip-select hold
  // ----------------------------------------------------------------
  // status and address are only valid while the strobe is sampled low
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      held_addr <= '0;
      mem_cs <= 4'h0;
      io_cs <= 4'h0;
      xcvr_direction <= 1'h0;
      mem_write <= 1'h0;
      cmd <= bioc_pkg::CMD_NONE;
    end
    else if (cycle_start)
    begin
      held_addr <= cpu_addr;
      mem_cs <= link.mem_cs;
      io_cs <= link.io_cs;
      xcvr_direction <= cpu_w_r;
      mem_write <= next_mem_write;
      cmd <= next_cmd;
    end
  end

  // ----------------------------------------------------------------
  // latch gate and latch output enable
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      latch_gate <= 1'b0;
      held_addr_oe_n <= 1'b0;
    end
    else
    begin
      latch_gate <= cycle_start;
      held_addr_oe_n <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // wait-state selection
  // ----------------------------------------------------------------
  // count comes from the captured selects, settled on the edge the gate rises
  assign io_slow = |(io_cs & IO_SLOW_MASK);

  always_comb
  begin
    next_wait_count = WS_OTHER;
    case (cmd)
      bioc_pkg::CMD_ROM_RD:
      begin
        next_wait_count = mem_cs[`BIOC_MEM_ROM_CS] ? WS_ROM : WS_RAM;
      end
      bioc_pkg::CMD_IO_RD, bioc_pkg::CMD_IO_WR:
      begin
        next_wait_count = (io_slow ? WS_IO_SLOW : WS_IO_FAST) + IO_RECOVERY;
      end
      bioc_pkg::CMD_INT_ACK:
      begin
        next_wait_count = WS_INT_ACK_CMD_N;
      end
      default:
      begin
        next_wait_count = mem_write ? WS_RAM : WS_OTHER;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      wait_start <= 1'b0;
    end
    else
    begin
      // counter loads one edge after the gate
      wait_start <= cycle_start;
    end
  end

  // ----------------------------------------------------------------
  // command strobes
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      rom_rd_cmd_n <= 1'b1;
      io_rd_cmd_n <= 1'b1;
      io_wr_cmd_n <= 1'b1;
      int_ack_cmd_n <= 1'b1;
    end
    // end and start are exclusive: they need different states
    else if (cycle_end)
    begin
      rom_rd_cmd_n <= 1'b1;
      io_rd_cmd_n <= 1'b1;
      io_wr_cmd_n <= 1'b1;
      int_ack_cmd_n <= 1'b1;
    end
    else if (cycle_start)
    begin
      rom_rd_cmd_n <= !(next_cmd == bioc_pkg::CMD_ROM_RD);
      io_rd_cmd_n <= !(next_cmd == bioc_pkg::CMD_IO_RD);
      io_wr_cmd_n <= !(next_cmd == bioc_pkg::CMD_IO_WR);
      int_ack_cmd_n <= !(next_cmd == bioc_pkg::CMD_INT_ACK);
    end
  end

  // ----------------------------------------------------------------
  // data transceiver enable
  // ----------------------------------------------------------------
  // companion peripheral drives the local bus itself on reads
  assign companion_read = !cpu_m_io && !cpu_w_r && cpu_d_c
    && link.io_cs[`BIOC_COMPANION_CS];

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      xcvr_enable_n <= 1'b1;
    end
    else if (cycle_end)
    begin
      xcvr_enable_n <= 1'b1;
    end
    else if (cycle_start)
    begin
      // halt and shutdown move no data
      xcvr_enable_n <= companion_read
        || ((next_cmd == bioc_pkg::CMD_NONE) && !next_mem_write);
    end
  end

  // ----------------------------------------------------------------
  // ready back to the processor
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      cpu_ready_n <= 1'b1;
    end
    else
    begin
      // one edge after the counter pulse, on the edge the strobes drop
      cpu_ready_n <= !cycle_end;
    end
  end

endmodule : bioc_bus_controller

`default_nettype wire

// *** bioc_defines.svh ***
`ifndef BIOC_DEFINES_SVH
`define BIOC_DEFINES_SVH

// ----------------------------------------------------------------
// address decode
// ----------------------------------------------------------------
`define BIOC_MEM_SEL_BIT 31
`define BIOC_IO_SEL_LO 4
`define BIOC_IO_SEL_HI 5
`define BIOC_MEM_ROM_CS 0
`define BIOC_MEM_RAM_CS 1
`define BIOC_MEM_IO_EN 2
`define BIOC_COMPANION_CS 0
`define BIOC_IO_SLOW_MASK 4'hC

// ----------------------------------------------------------------
// wait states
// ----------------------------------------------------------------
`define BIOC_WAIT_W 5
`define BIOC_WS_ROM 5'h02
`define BIOC_WS_RAM 5'h01
`define BIOC_WS_IO_FAST 5'h02
`define BIOC_WS_IO_SLOW 5'h04
`define BIOC_WS_INT_ACK_CMD_N 5'h05
`define BIOC_WS_OTHER 5'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define BIOC_CLK_PERIOD_NS 50
`define BIOC_IO_RECOVERY_NS 500
`define BIOC_IO_RECOVERY_CYC \
  ((`BIOC_IO_RECOVERY_NS + `BIOC_CLK_PERIOD_NS - 1) / `BIOC_CLK_PERIOD_NS)

`endif

// *** bioc_pkg.sv ***
`default_nettype none

package bioc_pkg;

  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_ROM_RD,
    CMD_IO_RD,
    CMD_IO_WR,
    CMD_INT_ACK
  } bioc_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ACTIVE,
    ST_DONE
  } bioc_state_t;

endpackage : bioc_pkg

`default_nettype wire

// *** bioc_link_if.sv ***
`timescale 1ns/10ps
`default_nettype none

interface bioc_link_if #(
  parameter int WAIT_W = 5
);
  logic mem_sel;
  logic [1:0] io_sel;
  logic m_io;
  logic d_c;
  logic [3:0] mem_cs;
  logic [3:0] io_cs;
  logic wait_start;
  logic [WAIT_W-1:0] wait_count;
  logic wait_done_n;

  modport ctl (
    output mem_sel,
    output io_sel,
    output m_io,
    output d_c,
    output wait_start,
    output wait_count,
    input mem_cs,
    input io_cs,
    input wait_done_n
  );

  modport dec (
    input mem_sel,
    input io_sel,
    input m_io,
    input d_c,
    output mem_cs,
    output io_cs
  );

  modport wct (
    input wait_start,
    input wait_count,
    output wait_done_n
  );
endinterface : bioc_link_if

`default_nettype wire

// *** bioc_decoder.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "bioc_defines.svh"

module bioc_decoder (
  bioc_link_if.dec link
);

  logic [1:0] mem_index;
  logic io_enable;

  // ----------------------------------------------------------------
  // memory decoder: io space is its third output
  // ----------------------------------------------------------------
  assign mem_index = {~link.m_io, link.mem_sel};

  // ----------------------------------------------------------------
  // one-of-four decoders, no storage
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_dec
      assign link.mem_cs[i] = (mem_index == 2'(i));
      assign link.io_cs[i] = io_enable && (link.io_sel == 2'(i));
    end
  endgenerate

  // interrupt acknowledge is an io-space cycle with d_c low; keep it off
  assign io_enable = link.mem_cs[`BIOC_MEM_IO_EN] && link.d_c;

endmodule : bioc_decoder

`default_nettype wire

// *** bioc_wait_counter.sv ***
`timescale 1ns/10ps
`default_nettype none

module bioc_wait_counter #(
  parameter int WAIT_W = 5
) (
  input wire logic core_clk,
  input wire logic reset,
  bioc_link_if.wct link
);

  logic [WAIT_W-1:0] remaining;
  logic busy;
  logic done_n;

  assign link.wait_done_n = done_n;

  // ----------------------------------------------------------------
  // down counter, one low pulse on done_n when it runs out
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      remaining <= '0;
      busy <= 1'b0;
      done_n <= 1'b1;
    end
    else
    begin
      done_n <= 1'b1;
      if (link.wait_start)
      begin
        remaining <= link.wait_count;
        busy <= 1'b1;
      end
      else if (busy)
      begin
        if (remaining == '0)
        begin
          done_n <= 1'b0;
          busy <= 1'b0;
        end
        else
        begin
          remaining <= remaining - 1'b1;
        end
      end
    end
  end

endmodule : bioc_wait_counter

`default_nettype wire

// *** bioc_bus_controller_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none

module bioc_bus_controller_assertions #(
  parameter int WS_ROM = 2
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [31:2] cpu_addr,
  input wire logic cpu_ads_n,
  input wire logic cpu_w_r,
  input wire logic cpu_m_io,
  input wire logic cpu_d_c,
  input wire logic [31:2] held_addr,
  input wire logic held_addr_oe_n,
  input wire logic latch_gate,
  input wire logic [3:0] io_cs,
  input wire logic xcvr_direction,
  input wire logic xcvr_enable_n,
  input wire logic rom_rd_cmd_n,
  input wire logic io_rd_cmd_n,
  input wire logic io_wr_cmd_n,
  input wire logic int_ack_cmd_n,
  input wire logic cpu_ready_n,
  input wire logic wait_done_n
);
  logic [3:0] cmds;
  logic [2:0] st;
  localparam int ROM_DELAY = WS_ROM + 2;
  assign cmds = {rom_rd_cmd_n, io_rd_cmd_n, io_wr_cmd_n, int_ack_cmd_n};
  assign st = {cpu_m_io, cpu_d_c, cpu_w_r};
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  // ------
  // cycle sequences
  // ------
  sequence s_done_ready;
    !wait_done_n ##1 !cpu_ready_n;
  endsequence
  sequence s_cycle_end;
    ##[3:17] !cpu_ready_n;
  endsequence

  chk_gate_source: assert property (latch_gate |-> !$past(cpu_ads_n) ##1 !latch_gate [*3])
    else $error("latch gate without start");
  chk_addr_capture: assert property (latch_gate |-> held_addr == $past(cpu_addr) && xcvr_direction == $past(cpu_w_r))
    else $error("capture wrong");
  chk_oe_enabled: assert property (!held_addr_oe_n)
    else $error("latch outputs off");
  chk_one_strobe: assert property ($countones(~cmds) <= 1)
    else $error("two strobes");
  chk_rom_decode: assert property (latch_gate |-> rom_rd_cmd_n != ($past(st) inside {3'h4, 3'h6}))
    else $error("rom strobe");
  chk_io_rd_cmd_n_decode: assert property (latch_gate |-> io_rd_cmd_n != ($past(st) == 3'h2))
    else $error("io read strobe");
  chk_io_wr_cmd_n_decode: assert property (latch_gate |-> io_wr_cmd_n != ($past(st) == 3'h3))
    else $error("io write strobe");
  chk_int_ack_cmd_n_decode: assert property (latch_gate |-> int_ack_cmd_n != ($past(st) == 3'h0))
    else $error("ack strobe");
  chk_ready_release: assert property (!cpu_ready_n |-> &cmds && xcvr_enable_n ##1 cpu_ready_n)
    else $error("strobe after ready");
  chk_cycle_bound: assert property (latch_gate |-> s_cycle_end)
    else $error("no ready");
  chk_companion_off: assert property (latch_gate && io_cs[0] && !io_rd_cmd_n |-> xcvr_enable_n)
    else $error("transceiver on");
  chk_io_recovery: assert property (latch_gate && !(io_rd_cmd_n && io_wr_cmd_n) |=> cpu_ready_n [*8] ##1 cpu_ready_n [*6])
    else $error("io cycle short");
  chk_rom_waits: assert property (latch_gate && !rom_rd_cmd_n && held_addr[31] == 1'h0 |-> ##ROM_DELAY s_done_ready)
    else $error("rom wait count");
endmodule : bioc_bus_controller_assertions

`default_nettype wire

// *** bioc_io_peripheral.sv ***
`timescale 1ns/10ps
`default_nettype none

module bioc_io_peripheral (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [3:0] io_cs,
  input wire logic io_rd_cmd_n,
  input wire logic io_wr_cmd_n,
  output logic [15:0] hits
);
  logic busy;
  // one hit per device where a command opens
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      busy <= 1'h0;
    else
      busy <= !(io_rd_cmd_n && io_wr_cmd_n);
  end
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      hits <= 16'h0000;
    else if (!busy && !(io_rd_cmd_n && io_wr_cmd_n))
      for (int i = 0; i < 4; i++)
        if (io_cs[i])
          hits[i*4 +: 4] <= hits[i*4 +: 4] + 4'h1;
  end
endmodule : bioc_io_peripheral

`default_nettype wire

// *** test_basic_io_bus_controller.sv ***
`timescale 1ns/10ps
`default_nettype none

module test_basic_io_bus_controller;
  logic core_clk = 1'h0;
  logic reset = 1'h1;
  logic [31:2] cpu_addr = 30'h0000_0000;
  logic cpu_ads_n = 1'h1;
  logic cpu_w_r = 1'h0;
  logic cpu_m_io = 1'h0;
  logic cpu_d_c = 1'h0;
  wire logic [31:2] held_addr;
  wire logic [3:0] mem_cs, io_cs;
  wire logic [15:0] hits;
  wire logic held_addr_oe_n, latch_gate, xcvr_direction, xcvr_enable_n, cpu_ready_n;
  wire logic rom_rd_cmd_n, io_rd_cmd_n, io_wr_cmd_n, int_ack_cmd_n, wait_done_n;
  wire logic [3:0] cmds = {rom_rd_cmd_n, io_rd_cmd_n, io_wr_cmd_n, int_ack_cmd_n};
  int err_total = 0;
  int num_checks = 0;

  bioc_bus_controller i_bioc_bus_controller (
    .core_clk, .reset, .cpu_addr, .cpu_ads_n, .cpu_w_r, .cpu_m_io, .cpu_d_c,
    .held_addr, .held_addr_oe_n, .latch_gate, .mem_cs, .io_cs, .xcvr_direction,
    .xcvr_enable_n, .rom_rd_cmd_n, .io_rd_cmd_n, .io_wr_cmd_n, .int_ack_cmd_n,
    .cpu_ready_n, .wait_done_n
  );
  bioc_io_peripheral i_bioc_io_peripheral (
    .core_clk, .reset, .io_cs, .io_rd_cmd_n, .io_wr_cmd_n, .hits
  );

  always #25 core_clk = ~core_clk;

  task summarize;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // ------
  // one bus cycle; pester raises a start request mid-cycle
  // ------
  task bus_cycle(input logic [31:2] a, input logic [2:0] st, input int n, input logic xen,
                 input logic pester);
    logic [3:0] cmd, mcs, ics;
    int kd, kr;
    cmd = st == 3'h0 ? 4'hE : st == 3'h2 ? 4'hB : st == 3'h3 ? 4'hD : 4'hF;
    cmd = (st == 3'h4 || st == 3'h6) ? 4'h7 : cmd;
    mcs = 4'h1 << {~st[2], a[31]};
    ics = (st[2:1] == 2'h1 && !a[31]) ? 4'h1 << a[5:4] : 4'h0;
    kd = 0;
    kr = 0;
    cpu_addr = a;
    {cpu_m_io, cpu_d_c, cpu_w_r} = st;
    cpu_ads_n = 1'h0;
    @(negedge core_clk);
    cpu_ads_n = 1'h1;
    cpu_addr = ~a;
    check({latch_gate, held_addr}, {1'h1, a});
    check({mem_cs, io_cs, xcvr_direction}, {mcs, ics, st[0]});
    check({cmds, xcvr_enable_n, held_addr_oe_n}, {cmd, xen, 1'h0});
    for (int k = 1; k <= 40 && kr == 0; k++)
    begin
      @(negedge core_clk);
      cpu_ads_n = !(pester && k == 2);
      if (wait_done_n === 1'h0)
        kd = k;
      if (cpu_ready_n === 1'h0)
        kr = k;
      else
        check({cmds, xcvr_enable_n}, {cmd, xen});
    end
    check(kd, n + 2);
    check(kr, n + 3);
    check({cmds, xcvr_enable_n}, 5'h1F);
    check(held_addr, a);
    @(negedge core_clk);
    check(cpu_ready_n, 1'h1);
  endtask : bus_cycle

  task t_reset_values;
    check({held_addr_oe_n, latch_gate, cmds, xcvr_enable_n, cpu_ready_n, wait_done_n}, 9'h07F);
    check(held_addr, 30'h0000_0000);
    check({mem_cs, io_cs, xcvr_direction}, 9'h000);
  endtask : t_reset_values

  task t_memory_cycles;
    bus_cycle(30'h0000_1234, 3'h4, 2, 1'h0, 1'h0);
    bus_cycle(30'h2000_0040, 3'h6, 1, 1'h0, 1'h0);
    bus_cycle(30'h2ABC_DEF0, 3'h7, 1, 1'h0, 1'h0);
    bus_cycle(30'h0000_0010, 3'h5, 0, 1'h1, 1'h0);
    bus_cycle(30'h0000_0020, 3'h1, 0, 1'h1, 1'h0);
  endtask : t_memory_cycles

  task t_io_devices;
    logic [31:2] a;
    for (int d = 0; d < 4; d++)
      for (int w = 0; w < 2; w++)
      begin
        a = 30'h0000_0100;
        a[5:4] = d[1:0];
        bus_cycle(a, {2'h1, w[0]}, d > 1 ? 14 : 12, d == 0 && w == 0, d == 3);
      end
    check(hits, 16'h2222);
    bus_cycle(30'h2000_0100, 3'h2, 12, 1'h0, 1'h0);
    check(hits, 16'h2222);
  endtask : t_io_devices

  task t_int_ack;
    bus_cycle(30'h0000_0000, 3'h0, 5, 1'h0, 1'h0);
    bus_cycle(30'h0000_0000, 3'h0, 5, 1'h0, 1'h0);
  endtask : t_int_ack

  task t_mid_reset;
    cpu_addr = 30'h0000_0100;
    {cpu_m_io, cpu_d_c, cpu_w_r} = 3'h2;
    cpu_ads_n = 1'h0;
    @(negedge core_clk);
    cpu_ads_n = 1'h1;
    @(negedge core_clk);
    reset = 1'h1;
    @(negedge core_clk);
    check({cmds, xcvr_enable_n, cpu_ready_n, latch_gate}, 7'h7E);
    reset = 1'h0;
    @(negedge core_clk);
    bus_cycle(30'h2000_0000, 3'h4, 1, 1'h0, 1'h0);
  endtask : t_mid_reset

  initial
  begin
    repeat (4000) @(posedge core_clk);
    err_total++;
    summarize();
  end

  initial
  begin
    repeat (20) @(negedge core_clk);
    reset = 1'h0;
    @(negedge core_clk);
    t_reset_values();
    t_memory_cycles();
    t_io_devices();
    t_int_ack();
    t_mid_reset();
    summarize();
  end
endmodule : test_basic_io_bus_controller

bind bioc_bus_controller bioc_bus_controller_assertions #(.WS_ROM(WS_ROM))
  i_bioc_bus_controller_assertions (
  .core_clk, .reset, .cpu_addr, .cpu_ads_n, .cpu_w_r, .cpu_m_io, .cpu_d_c, .held_addr,
  .held_addr_oe_n, .latch_gate, .io_cs, .xcvr_direction, .xcvr_enable_n, .rom_rd_cmd_n,
  .io_rd_cmd_n, .io_wr_cmd_n, .int_ack_cmd_n, .cpu_ready_n, .wait_done_n
);

`default_nettype wire
